// File: inc/ivam_map.svh
`ifndef IVAM_MAP_SVH
`define IVAM_MAP_SVH

// Reset address, interrupt vector number range and source count of the fixed table
`define IVAM_RESET_ADDR 17'h00000
`define IVAM_VEC_FIRST_IRQ 5'h02
`define IVAM_VEC_LAST_IRQ 5'h1e
`define IVAM_NUM_SRC 29
// Boot section start in program words; a strap of the device
`define IVAM_BOOT_START_RST 17'h1f000

`endif

// File: inc/ivam_pkg.sv
package ivam_pkg;
    typedef struct packed {
        logic [7:0] ext_pin_request;
        logic [2:0] pin_change_group;
        logic watchdog_timeout_event;
        logic t2_compare_match_a;
        logic t2_compare_match_b;
        logic t2_counter_overflow;
        logic t1_input_capture_event;
        logic t1_compare_match_a;
        logic t1_compare_match_b;
        logic t1_compare_match_c;
        logic t1_counter_overflow;
        logic t0_compare_match_a;
        logic t0_compare_match_b;
        logic t0_counter_overflow;
        logic serial_transfer_complete;
        logic uart0_rx_complete;
        logic tx_buffer_empty;
        logic uart0_tx_complete;
        logic analog_compare_event;
        logic conversion_complete;
    } ivam_src_t;

    typedef struct packed {
        logic valid;
        logic is_reset;
        logic [4:0] number;
        logic [16:0] addr;
    } ivam_vec_t;

    typedef enum logic [1:0] {
        IVAM_IDLE = 2'b00,
        IVAM_RESET = 2'b01,
        IVAM_IRQ = 2'b10
    } ivam_state_t;
endpackage

// File: rtl/ivam_prio.sv
`timescale 1ns/1ps
`include "ivam_map.svh"

// Lowest set bit wins; bit 0 is the highest priority
module ivam_prio #(
    parameter int N = 29
) (
    input wire logic [N-1:0] req,
    output logic any,
    output logic [4:0] index
);
    always_comb begin
        any = 1'b0;
        index = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                index = 5'(i);
            end
        end
    end
endmodule

// File: rtl/ivam_vector_map.sv
`timescale 1ns/1ps
`include "ivam_map.svh"

// What this block does
// - Every reset cause uses vector one, address zero unless the boot fuse is set
// - External requests 0-7 take vectors 2-9
// - Pin-change groups 0-2 at 0x12, 0x14, 0x16
// - Timer 2 events at 0x1a, 0x1c, 0x1e
// - Timer 1 events at 0x20 through 0x28
// - Timer 0 events at 0x2a, 0x2c, 0x2e
// - Serial transfer complete is vector 25, 0x30
// - First serial port at 0x32, 0x34, 0x36
// - Relocate bit adds boot section start to interrupt vectors, not to the reset vector
// - Boot fuse starts reset at boot address
module ivam_vector_map (
    input wire logic clock,
    input wire logic rst_b,
    input wire ivam_pkg::ivam_src_t pending,
    input wire logic [4:0] reset_cause,
    input wire logic vector_relocate_select,
    input wire logic boot_reset_fuse,
    input wire logic [16:0] boot_start,
    input wire logic vector_taken,
    output ivam_pkg::ivam_vec_t vector
);
    ivam_pkg::ivam_state_t state;
    ivam_pkg::ivam_state_t next_state;
    ivam_pkg::ivam_vec_t next_vector;
    logic reset_seen;
    logic reset_any_q;
    wire logic reset_any;
    wire logic reset_new;
    logic [16:0] boot_latched;
    logic [`IVAM_NUM_SRC-1:0] req_bits;
    logic req_any;
    logic [4:0] req_index;
    wire logic [4:0] irq_number;
    wire logic [16:0] table_addr;
    wire logic [16:0] reloc_base;
    wire logic [16:0] reset_addr;

    // Vector order: external 0-7, pin change 0-2, then the single-bit sources,
    // which the struct lists from its top bit down
    always_comb begin
        req_bits[7:0] = pending.ext_pin_request;
        req_bits[10:8] = pending.pin_change_group;
        for (int i = 11; i < `IVAM_NUM_SRC; i++) begin
            req_bits[i] = pending[`IVAM_NUM_SRC - 1 - i];
        end
    end

    assign reset_any = |reset_cause;
    assign reset_new = reset_any && !reset_any_q;

    ivam_prio #(.N(`IVAM_NUM_SRC)) u_prio (
        .req(req_bits),
        .any(req_any),
        .index(req_index)
    );

    // Bit 0 is vector 2; external 2-9, pin change 10-12, watchdog 13, timers 14-24, etc.
    assign irq_number = req_index + `IVAM_VEC_FIRST_IRQ;
    // Two program words per entry: address = 2 * (n - 1)
    assign table_addr = {11'h000, irq_number - 5'h01, 1'b0};
    assign reloc_base = vector_relocate_select ? boot_latched : 17'h00000;
    assign reset_addr = boot_reset_fuse ? boot_latched : `IVAM_RESET_ADDR;

    always_comb begin
        next_state = state;
        next_vector = vector;
        case (state)
            ivam_pkg::IVAM_IDLE: begin
                if (reset_seen) begin
                    next_state = ivam_pkg::IVAM_RESET;
                    next_vector = '{1'b1, 1'b1, 5'h01, reset_addr};
                end else if (req_any) begin
                    next_state = ivam_pkg::IVAM_IRQ;
                    next_vector = '{1'b1, 1'b0, irq_number, 17'(table_addr + reloc_base)};
                end
            end
            ivam_pkg::IVAM_RESET, ivam_pkg::IVAM_IRQ: begin
                if (vector_taken) begin
                    next_state = ivam_pkg::IVAM_IDLE;
                    next_vector = '0;
                end
            end
            default: begin
                next_state = ivam_pkg::IVAM_IDLE;
                next_vector = '0;
            end
        endcase
    end

    // Boot start is a strap: sampled whenever idle, reset included, so it is
    // already valid for the reset vector at the first edge after release
    always_ff @(posedge clock) begin
        if (state == ivam_pkg::IVAM_IDLE && !vector.valid) begin
            boot_latched <= boot_start;
        end
    end

    // A held cause counts once; a new cause on the take edge wins over the clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reset_seen <= 1'b1;
            reset_any_q <= 1'b0;
        end else begin
            reset_any_q <= reset_any;
            if (reset_new) begin
                reset_seen <= 1'b1;
            end else if (state == ivam_pkg::IVAM_RESET && vector_taken) begin
                reset_seen <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ivam_pkg::IVAM_IDLE;
            vector <= '0;
        end else begin
            state <= next_state;
            vector <= next_vector;
        end
    end

    reset_first_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && reset_seen)
        |=> vector.number == 5'h01 && vector.is_reset)
        else $error("reset cause did not yield vector one");
    reset_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
        (vector.is_reset && $rose(vector.valid)) |->
        vector.addr == ($past(boot_reset_fuse) ? $past(boot_latched) : 17'h00000))
        else $error("reset address wrong");
    ext0_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending.ext_pin_request[0]
        && !vector_relocate_select) |=> vector.addr == 17'h00002)
        else $error("external request 0 address wrong");
    ext7_num_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h10000000)
        |=> vector.number == 5'h09)
        else $error("external request 7 vector wrong");
    pcg0_num_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0040000
        && !vector_relocate_select)
        |=> vector.number == 5'h0a && vector.addr == 17'h00012)
        else $error("pin change group 0 vector wrong");
    pcg2_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0100000
        && !vector_relocate_select) |=> vector.addr == 17'h00016)
        else $error("pin change group 2 address wrong");
    t2_ovf_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0004000
        && !vector_relocate_select) |=> vector.addr == 17'h0001e)
        else $error("timer 2 overflow address wrong");
    t1_input_capture_event_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0002000
        && !vector_relocate_select) |=> vector.addr == 17'h00020)
        else $error("timer 1 capture address wrong");
    t1_ovf_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0000200
        && !vector_relocate_select) |=> vector.addr == 17'h00028)
        else $error("timer 1 overflow address wrong");
    t0_ova_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0000040
        && !vector_relocate_select) |=> vector.addr == 17'h0002e)
        else $error("timer 0 overflow address wrong");
    spi_vec_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0000020
        && !vector_relocate_select)
        |=> vector.number == 5'd25 && vector.addr == 17'h00030)
        else $error("serial transfer vector wrong");
    uart_tx_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending == 29'h0000004
        && !vector_relocate_select) |=> vector.addr == 17'h00036)
        else $error("serial port tx complete address wrong");
    reloc_add_a: assert property (@(posedge clock) disable iff (!rst_b)
        ($rose(vector.valid) && !vector.is_reset && $past(vector_relocate_select)) |->
        vector.addr == 17'({11'h000, vector.number - 5'h01, 1'b0} + $past(boot_latched)))
        else $error("relocated vector address wrong");
    lowest_wins_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ivam_pkg::IVAM_IDLE && !reset_seen && pending.ext_pin_request[1]
        && !pending.ext_pin_request[0]) |=> vector.number == 5'h03)
        else $error("lower vector did not win");
    hold_until_a: assert property (@(posedge clock) disable iff (!rst_b)
        (vector.valid && !vector_taken) |=> vector.valid && $stable(vector.addr))
        else $error("vector dropped before taken");
    taken_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        (vector.valid && vector_taken) |=> !vector.valid)
        else $error("vector stood after it was taken");
endmodule

// File: bench/ivam_core_model.sv
`timescale 1ns/1ps
// Core side: takes each presented vector after a chosen number of wait cycles
module ivam_core_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire ivam_pkg::ivam_vec_t vector,
    input wire logic [3:0] stall,
    output logic vector_taken,
    output logic got,
    output ivam_pkg::ivam_vec_t seen
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            vector_taken <= 1'b0;
            got <= 1'b0;
            seen <= '0;
            wait_cnt <= 4'h0;
        end else begin
            got <= vector_taken;
            if (vector_taken) begin
                seen <= vector;
                vector_taken <= 1'b0;
                wait_cnt <= 4'h0;
            end else if (vector.valid && wait_cnt == stall) begin
                vector_taken <= 1'b1;
            end else if (vector.valid) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [16:0] BOOT = 17'h1e000;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    ivam_pkg::ivam_src_t pending = '0;
    logic [4:0] reset_cause = 5'h00;
    logic relocate = 1'b0;
    logic fuse = 1'b0;
    logic [3:0] stall = 4'h0;
    logic vector_taken;
    logic got;
    ivam_pkg::ivam_vec_t vector;
    ivam_pkg::ivam_vec_t seen;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    always #4 clock = ~clock;
    ivam_vector_map i_ivam_vector_map (.clock(clock), .rst_b(rst_b), .pending(pending),
        .reset_cause(reset_cause), .vector_relocate_select(relocate),
        .boot_reset_fuse(fuse), .boot_start(BOOT), .vector_taken(vector_taken),
        .vector(vector));
    ivam_core_model i_ivam_core_model (.clock(clock), .rst_b(rst_b), .vector(vector),
        .stall(stall), .vector_taken(vector_taken), .got(got), .seen(seen));
    task automatic wrap_up();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic check(input logic [23:0] got_v, input logic [23:0] exp_v);
        checks_done++;
        if (got_v !== exp_v) begin
            n_fail++;
            $display("[FAIL] %0t vector %h expected %h", $time, got_v, exp_v);
        end
    endtask
    function automatic logic [28:0] src(input int n);
        if (n <= 9) return 29'h1 << (21 + n - 2);
        if (n <= 12) return 29'h1 << (18 + n - 10);
        return 29'h1 << (30 - n);
    endfunction
    function automatic logic [23:0] expv(input int n, input logic [16:0] base);
        return {1'b1, n == 1, 5'(n), base + 17'(2 * (n - 1))};
    endfunction
    // Requests stay up until the core has taken the vector, as a real core would.
    // A reset cause goes up one cycle ahead: the block registers it before choosing.
    task automatic serve(input logic [28:0] req, input logic [4:0] cause,
        input logic [23:0] exp_v);
        int t;
        @(posedge clock);
        #1;
        reset_cause = cause;
        @(posedge clock);
        #1;
        pending = req;
        for (t = 0; t < 40 && !got; t++) begin
            @(posedge clock);
            #1;
        end
        pending = '0;
        reset_cause = 5'h00;
        check(seen, exp_v);
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        rst_b = 1'b1;
    endtask
    task automatic t_table();
        for (int n = 2; n <= 30; n++) begin
            serve(src(n), 5'h00, expv(n, 17'h0));
        end
    endtask
    task automatic t_priority();
        serve('1, 5'h00, expv(2, 17'h0));
        for (int n = 3; n <= 25; n++) serve(src(n) | src(n + 5), 5'h00, expv(n, 17'h0));
        serve('1, 5'h01, expv(1, 17'h0));
    endtask
    task automatic t_causes();
        for (int k = 0; k < 5; k++) serve('0, 5'h01 << k, expv(1, 17'h0));
    endtask
    // Slow core here, so the vector must stand across the wait
    task automatic t_relocate();
        relocate = 1'b1;
        stall = 4'h3;
        for (int n = 2; n <= 30; n++) serve(src(n), 5'h00, expv(n, BOOT));
        serve('0, 5'h10, expv(1, 17'h0));
        relocate = 1'b0;
        stall = 4'h0;
    endtask
    task automatic t_fuse();
        fuse = 1'b1;
        serve('0, 5'h04, expv(1, BOOT));
        do_reset();
        serve('0, 5'h00, expv(1, BOOT));
        fuse = 1'b0;
    endtask
    initial begin
        do_reset();
        serve('0, 5'h00, expv(1, 17'h0));
        t_table();
        t_priority();
        t_causes();
        t_relocate();
        t_fuse();
        wrap_up();
    end
endmodule
